// >>> logic/msc_map.svh
/*
 * Constants of the modem switch configuration decoder: switch positions,
 * factory values, rate coding and debounce length.
 * Assumes switch inputs read 1 for On and 0 for Off.
 */
// What this block does
// [RL1] Bank-two positions 6,7 select internal, terminal or recovered clock; Off/Off reserved.
// [RL2] Bank-two position 8 On honours terminal loop requests; Off ignores them.
// [RL3] Bank-three positions 1-6 decode exactly to 64..2304 kbps terminal rate.
// [RL4] Line rate is the lowest one that still carries the terminal rate.
// [RL5] Bank-three position 7 Off restores software settings to factory defaults.
// [RL6] Bank-three position 8 On samples transmit data on falling transmit clock edge.
// [RL7] Bank-three position 8 Off samples transmit data on rising transmit clock edge.
// [RL8] A customer-premise unit with all switches On runs as plug-and-play.
// [RL9] Plug-and-play unit starts with defaults and receive-recovered clocking.
// [RL10] Central office sets terminal and line rate in handshake; premise unit adopts them.
// [RL11] Plug-and-play unit keeps every other setting at its default.
// [RL12] Central office of a plug-and-play pair never uses recovered clocking; not enforced here, its switches may still select it.
// [RL13] Rate changes come only from the central office; premise unit follows.
// [RL14] Switches are synchronised and must be stable several samples before use.
// [RL15] Unknown rate codes and reserved clock code are flagged; last valid kept.
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

// ------------------------------------------------------------------
// Switch positions (bit index within a bank)
// ------------------------------------------------------------------
`define MSC_S2_CLK_A        5
`define MSC_S2_CLK_B        6
`define MSC_S2_LOOP         7
`define MSC_S3_RATE_HI      5
`define MSC_S3_NORMAL       6
`define MSC_S3_EDGE         7

// ------------------------------------------------------------------
// Rate coding and factory values
// ------------------------------------------------------------------
`define MSC_RATE_SHIFT      6
`define MSC_RATE_V_MIN      6'h03
`define MSC_RATE_V_MAX      6'h27
`define MSC_RATE_HOLE_A     6'h14
`define MSC_RATE_HOLE_B     6'h1b
`define MSC_RATE_V_SPLIT    6'h1c
`define MSC_DEF_RATE_CODE   6'h0c
`define MSC_LINE_MIN_KBPS   12'h090
`define MSC_LINE_OVH_KBPS   12'h010
`define MSC_DEBOUNCE_SAMPLES 8

`endif

// >>> logic/msc_pkg.sv
/*
 * Types of the modem switch configuration decoder.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package msc_pkg;

	typedef enum logic [1:0] {
		MSC_CLK_INTERNAL  = 2'h0,
		MSC_CLK_TERMINAL  = 2'h1,
		MSC_CLK_RECOVERED = 2'h2
	} msc_clk_mode_t;

	typedef enum logic [1:0] {
		MSC_LOCAL       = 2'h0,
		MSC_PNP_DEFAULT = 2'h1,
		MSC_PNP_ADOPTED = 2'h3
	} msc_pnp_state_t;

endpackage : msc_pkg

// >>> logic/msc_config_decoder.sv
/*
 * Switch configuration decoder of a symmetric line modem: debounces three
 * switch banks, decodes clock mode, loop response, rates, defaults reset and
 * transmit data sampling edge, and handles plug-and-play rate adoption.
 * Assumes switches, strap, loop request, transmit data and the three clock
 * sources are asynchronous pins; peer rate words come from handshake logic
 * on clk_sys. Clock sources must be far slower than clk_sys.
 */
`timescale 1ns/10ps
`include "msc_map.svh"

module msc_config_decoder #(
	parameter int DEB_SAMPLES = `MSC_DEBOUNCE_SAMPLES
) (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// Configuration switches and strap
	input  wire logic [7:0]             switch_bank_one,
	input  wire logic [7:0]             switch_bank_two,
	input  wire logic [7:0]             switch_bank_three,
	input  wire logic                   unit_is_customer_premise,
	// Terminal side
	input  wire logic                   terminal_loop_request,
	input  wire logic                   serial_transmit_line,
	// Transmit clock sources
	input  wire logic                   clk_src_internal,
	input  wire logic                   clk_src_terminal,
	input  wire logic                   clk_src_recovered,
	// Rates from the central office handshake
	input  wire logic                   peer_rate_valid,
	input  wire logic [5:0]             peer_rate_code,
	input  wire logic [11:0]            peer_line_kbps,
	// Decoded settings
	output logic [1:0]                  tx_clock_mode,
	output logic                        loopback_enable,
	output logic [5:0]                  terminal_rate_code,
	output logic [11:0]                 terminal_rate_kbps,
	output logic [11:0]                 line_rate_kbps,
	output logic                        restore_defaults,
	output logic                        sample_on_falling,
	output logic                        plug_and_play_active,
	output logic                        config_invalid,
	// Transmit clock and sampled data
	output logic                        terminal_tx_clock_out,
	output logic                        tx_data_bit,
	output logic                        tx_data_strobe
);
	import msc_pkg::*;

	localparam int DCW = $clog2(DEB_SAMPLES + 1);

	if (DEB_SAMPLES < 2 || DEB_SAMPLES > 1024) begin : g_bad_deb
		$error("msc_config_decoder: DEB_SAMPLES must lie in 2..1024");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [23:0]    sw_meta;
		logic [23:0]    sw_sync;
		logic [23:0]    sw_cand;
		logic [23:0]    sw_stab;
		logic [DCW-1:0] deb_cnt;
		logic           settled;
		logic [5:0]     pin_meta;
		logic [5:0]     pin_sync;
		msc_clk_mode_t  clk_mode;
		logic           loop_allow;
		logic           loop_en;
		logic [5:0]     rate_code;
		logic [11:0]    rate_kbps;
		logic [11:0]    line_kbps;
		logic           restore;
		logic           fall_edge;
		logic           invalid;
		msc_pnp_state_t pnp;
		logic           txc;
		logic           tx_bit;
		logic           tx_stb;
	} msc_state_t;

	msc_state_t st_reg;
	msc_state_t st_next;

	// ------------------------------------------------------------------
	// Rate decode helpers
	// ------------------------------------------------------------------
	// Switch On reads 1 but codes as 0, position 1 is the low bit. The table
	// runs in order with two holes, so an offset of two below the upper hole
	// and three above it reproduces every printed entry exactly.
	function automatic logic [6:0] msc_rate_lookup(input logic [5:0] sw);
		logic [5:0] v;
		logic [6:0] r;
		v = ~sw;
		r = 7'h00;
		if (v < `MSC_RATE_V_MIN || v > `MSC_RATE_V_MAX) begin
			r = 7'h00;
		end else if (v == `MSC_RATE_HOLE_A || v == `MSC_RATE_HOLE_B) begin
			r = 7'h00;
		end else if (v < `MSC_RATE_V_SPLIT) begin
			r = {1'b1, 6'(v - 6'h02)};
		end else begin
			r = {1'b1, 6'(v - 6'h03)};
		end
		return r;
	endfunction : msc_rate_lookup

	function automatic logic [11:0] msc_line_for(input logic [11:0] kbps);
		logic [11:0] need;
		need = kbps + `MSC_LINE_OVH_KBPS;
		return (need < `MSC_LINE_MIN_KBPS) ? `MSC_LINE_MIN_KBPS : need;
	endfunction : msc_line_for

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [7:0]    b2;
		logic [7:0]    b3;
		logic [6:0]    lut;
		logic          all_on;
		logic          pnp_now;
		logic          sel_clk;
		logic          do_sample;
		msc_clk_mode_t sw_mode;
		logic          mode_ok;
		logic          peer_ok;
		st_next   = st_reg;
		b2        = st_reg.sw_stab[15:8];
		b3        = st_reg.sw_stab[23:16];
		lut       = 7'h00;
		all_on    = 1'b0;
		pnp_now   = 1'b0;
		sel_clk   = 1'b0;
		do_sample = 1'b0;
		sw_mode   = MSC_CLK_INTERNAL;
		mode_ok   = 1'b0;
		peer_ok   = 1'b0;

		// Two flip-flops ahead of the switches, strap, loop request, transmit data and clock sources.
		st_next.sw_meta  = {switch_bank_three, switch_bank_two, switch_bank_one};
		st_next.sw_sync  = st_reg.sw_meta;
		st_next.pin_meta = {clk_src_recovered, clk_src_terminal, clk_src_internal,
		                    serial_transmit_line, terminal_loop_request,
		                    unit_is_customer_premise};
		st_next.pin_sync = st_reg.pin_meta;

		// A new switch pattern is taken only after it held for DEB_SAMPLES.
		if (st_reg.sw_sync != st_reg.sw_cand) begin // RL14
			st_next.sw_cand = st_reg.sw_sync;
			st_next.deb_cnt = '0;
		end else if (st_reg.deb_cnt != DCW'(DEB_SAMPLES)) begin
			st_next.deb_cnt = st_reg.deb_cnt + DCW'(1);
		end else begin
			st_next.sw_stab = st_reg.sw_cand; // RL14
			st_next.settled = 1'b1;
		end

		all_on  = &st_reg.sw_stab;
		pnp_now = st_reg.settled && st_reg.pin_sync[0] && all_on; // RL8

		case ({b2[`MSC_S2_CLK_A], b2[`MSC_S2_CLK_B]}) // RL1
			2'b11:   sw_mode = MSC_CLK_INTERNAL;
			2'b01:   sw_mode = MSC_CLK_TERMINAL;
			2'b10:   sw_mode = MSC_CLK_RECOVERED;
			default: sw_mode = MSC_CLK_INTERNAL;
		endcase
		mode_ok = b2[`MSC_S2_CLK_A] | b2[`MSC_S2_CLK_B];
		lut = msc_rate_lookup(b3[`MSC_S3_RATE_HI:0]); // RL3
		// A peer word with an impossible rate is dropped whole, line rate included.
		peer_ok = peer_rate_valid && (peer_rate_code != 6'h00) &&
		          (peer_rate_code <= 6'(`MSC_RATE_V_MAX - 6'h03));

		case (st_reg.pnp)
			MSC_LOCAL: begin
				if (pnp_now) begin
					st_next.pnp = MSC_PNP_DEFAULT;
				end
			end
			MSC_PNP_DEFAULT: begin
				if (!pnp_now) begin
					st_next.pnp = MSC_LOCAL;
				end else if (peer_rate_valid) begin
					st_next.pnp = MSC_PNP_ADOPTED; // RL10
				end
			end
			MSC_PNP_ADOPTED: begin
				if (!pnp_now) begin
					st_next.pnp = MSC_LOCAL;
				end
			end
			default: st_next.pnp = MSC_LOCAL;
		endcase

		if (st_reg.settled && !pnp_now) begin
			// Local switches rule; bad codes keep the last good value.
			st_next.invalid = !lut[6] || !mode_ok; // RL15
			if (mode_ok) begin
				st_next.clk_mode = sw_mode; // RL1
			end
			if (lut[6]) begin
				st_next.rate_code = lut[5:0]; // RL3
			end
			st_next.loop_allow = b2[`MSC_S2_LOOP]; // RL2
			st_next.restore    = !b3[`MSC_S3_NORMAL]; // RL5
			st_next.fall_edge  = b3[`MSC_S3_EDGE];
		end else if (pnp_now) begin
			// Everything but the rates stays at the plug-and-play default.
			st_next.invalid    = 1'b0;
			st_next.clk_mode   = MSC_CLK_RECOVERED; // RL9
			st_next.loop_allow = 1'b0; // RL11
			st_next.restore    = 1'b0; // RL11
			st_next.fall_edge  = 1'b1; // RL11
			if (st_reg.pnp == MSC_LOCAL) begin
				st_next.rate_code = `MSC_DEF_RATE_CODE; // RL9
			end
			if (peer_ok) begin
				st_next.rate_code = peer_rate_code; // RL13
			end
		end

		st_next.rate_kbps = {st_next.rate_code, 6'h00};
		if (pnp_now && peer_ok && peer_line_kbps >= st_next.rate_kbps) begin
			st_next.line_kbps = peer_line_kbps; // RL10
		end else if (!pnp_now || st_reg.pnp == MSC_LOCAL) begin
			st_next.line_kbps = msc_line_for(st_next.rate_kbps); // RL4
		end

		// Gate with the new permission so entering plug-and-play drops loops at once.
		st_next.loop_en = st_next.loop_allow && st_reg.pin_sync[1]; // RL2

		// Transmit clock follows the chosen source; data is taken on the edge
		// of our own output so the terminal sees a consistent relation.
		case (st_reg.clk_mode)
			MSC_CLK_TERMINAL:  sel_clk = st_reg.pin_sync[4];
			MSC_CLK_RECOVERED: sel_clk = st_reg.pin_sync[5];
			default:           sel_clk = st_reg.pin_sync[3];
		endcase
		st_next.txc = sel_clk;
		if (st_reg.fall_edge) begin
			do_sample = st_reg.txc && !sel_clk; // RL6
		end else begin
			do_sample = !st_reg.txc && sel_clk; // RL7
		end
		st_next.tx_stb = do_sample;
		if (do_sample) begin
			st_next.tx_bit = st_reg.pin_sync[2];
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg            <= '0;
			st_reg.clk_mode   <= MSC_CLK_RECOVERED;
			st_reg.rate_code  <= `MSC_DEF_RATE_CODE;
			st_reg.rate_kbps  <= {`MSC_DEF_RATE_CODE, 6'h00};
			st_reg.line_kbps  <= {`MSC_DEF_RATE_CODE, 6'h00} + `MSC_LINE_OVH_KBPS;
			st_reg.fall_edge  <= 1'b1;
			st_reg.pnp        <= MSC_LOCAL;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tx_clock_mode         = st_reg.clk_mode;
	assign loopback_enable       = st_reg.loop_en;
	assign terminal_rate_code    = st_reg.rate_code;
	assign terminal_rate_kbps    = st_reg.rate_kbps;
	assign line_rate_kbps        = st_reg.line_kbps;
	assign restore_defaults      = st_reg.restore;
	assign sample_on_falling     = st_reg.fall_edge;
	assign plug_and_play_active  = st_reg.pnp[0];
	assign config_invalid        = st_reg.invalid;
	assign terminal_tx_clock_out = st_reg.txc;
	assign tx_data_bit           = st_reg.tx_bit;
	assign tx_data_strobe        = st_reg.tx_stb;

endmodule : msc_config_decoder

// >>> sim/msc_config_sva.sv
/* Checker of the switch configuration decoder, bound to its ports.
 * Assumes one clock domain, clk_sys, with asynchronous reset rst. */
`timescale 1ns/10ps

module msc_config_sva #(
	parameter int DEB_SAMPLES = 8
) (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Inputs watched
	input wire logic [7:0]  switch_bank_two,
	input wire logic        terminal_loop_request,
	input wire logic        peer_rate_valid,
	input wire logic [5:0]  peer_rate_code,
	// Outputs watched
	input wire logic [1:0]  tx_clock_mode,
	input wire logic        loopback_enable,
	input wire logic [5:0]  terminal_rate_code,
	input wire logic [11:0] terminal_rate_kbps,
	input wire logic [11:0] line_rate_kbps,
	input wire logic        restore_defaults,
	input wire logic        sample_on_falling,
	input wire logic        plug_and_play_active,
	input wire logic        terminal_tx_clock_out,
	input wire logic        tx_data_strobe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	mode_legal_a: assert property (tx_clock_mode != 2'h3)
		else $error("reserved clock mode driven");
	loop_gate_a: assert property ($rose(loopback_enable) |->
		$past(terminal_loop_request, 3) && $past(switch_bank_two[7], 2))
		else $error("loopback without request");
	loop_off_a: assert property (!terminal_loop_request [*4] |-> !loopback_enable)
		else $error("loopback stays without request");
	rate_kbps_a: assert property (terminal_rate_kbps == {terminal_rate_code, 6'h00})
		else $error("rate kbps not code times 64");
	line_rule_a: assert property (!plug_and_play_active && !$past(plug_and_play_active) |->
		line_rate_kbps == ((terminal_rate_kbps > 12'h080) ? terminal_rate_kbps + 12'h010 : 12'h090))
		else $error("line rate not lowest fit");
	pnp_entry_a: assert property ($rose(plug_and_play_active) |->
		tx_clock_mode == 2'h2 && terminal_rate_code == 6'h0c)
		else $error("plug-and-play start config wrong");
	pnp_cfg_a: assert property (plug_and_play_active |->
		!restore_defaults && sample_on_falling && !loopback_enable && tx_clock_mode == 2'h2)
		else $error("plug-and-play setting off default");
	peer_take_a: assert property (
		plug_and_play_active && peer_rate_valid && peer_rate_code inside {[6'h01:6'h24]}
		|=> !plug_and_play_active || terminal_rate_code == $past(peer_rate_code))
		else $error("peer rate not adopted");
	strobe_edge_a: assert property (tx_data_strobe && $stable(sample_on_falling) |->
		(sample_on_falling ? $fell(terminal_tx_clock_out) : $rose(terminal_tx_clock_out)))
		else $error("data sampled on wrong edge");

	cover property ($rose(plug_and_play_active));
	cover property (tx_data_strobe && !sample_on_falling);
	cover property ($rose(loopback_enable));
endmodule : msc_config_sva

bind msc_config_decoder msc_config_sva #(.DEB_SAMPLES(DEB_SAMPLES)) u_msc_config_sva (
	.clk_sys, .rst, .switch_bank_two, .terminal_loop_request, .peer_rate_valid,
	.peer_rate_code, .tx_clock_mode, .loopback_enable, .terminal_rate_code,
	.terminal_rate_kbps, .line_rate_kbps, .restore_defaults, .sample_on_falling,
	.plug_and_play_active, .terminal_tx_clock_out, .tx_data_strobe);

// >>> sim/msc_peer_model.sv
/* Terminal and central-office peer: terminal clock, transmit data,
 * line clock and handshake rate words.
 * Assumes the bench calls offer() from its main sequence. */
`timescale 1ns/10ps

module msc_peer_model (
	// Clock
	input wire logic    clk_sys,
	// Peer side
	output logic        clk_src_terminal,
	output logic        clk_src_recovered,
	output logic        serial_transmit_line,
	output logic        peer_rate_valid,
	output logic [5:0]  peer_rate_code,
	output logic [11:0] peer_line_kbps
);
	initial begin
		clk_src_terminal = 1'b0;
		clk_src_recovered = 1'b0;
		serial_transmit_line = 1'b1;
		peer_rate_valid = 1'b0;
		peer_rate_code = 6'h2a;
		peer_line_kbps = 12'h5a5;
	end

	// The peer times from its own oscillator, never from our line.
	initial #1 forever #62.5 clk_src_recovered = ~clk_src_recovered;
	initial #17 forever #62.5 clk_src_terminal = ~clk_src_terminal;
	always @(posedge clk_src_terminal) serial_transmit_line <= ~serial_transmit_line;

	// Words are valid only with the pulse; afterwards the bus carries junk.
	task automatic offer(input logic [5:0] c, input logic [11:0] l);
		@(negedge clk_sys);
		peer_rate_code = c;
		peer_line_kbps = l;
		peer_rate_valid = 1'b1;
		@(negedge clk_sys);
		peer_rate_valid = 1'b0;
		peer_rate_code = ~c;
		peer_line_kbps = ~l;
	endtask : offer
endmodule : msc_peer_model

// >>> sim/tb_top.sv
/* Self-checking bench of the switch configuration decoder.
 * Assumes the package, design, checker and peer model compile first. */
`timescale 1ns/10ps

module tb_top;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  b1 = 8'hff;
	logic [7:0]  b2 = 8'h60;
	logic [7:0]  b3 = 8'hf1;
	logic        strap = 1'b0;
	logic        lreq = 1'b0;
	logic        clk_int = 1'b0;
	logic        tclk, rclk, txd, pv, loop, rstd, fall, pnp, inv, tco, tbit, stb;
	logic [5:0]  pc, rcode;
	logic [1:0]  mode;
	logic [11:0] pl, rkbps, lkbps;
	int          errors = 0;
	int          checked = 0;

	always #2.5 clk_sys = ~clk_sys;
	initial #2 forever #62.5 clk_int = ~clk_int;

	msc_config_decoder #(.DEB_SAMPLES(2)) u_msc_config_decoder (
		.clk_sys(clk_sys), .rst(rst), .switch_bank_one(b1), .switch_bank_two(b2),
		.switch_bank_three(b3), .unit_is_customer_premise(strap),
		.terminal_loop_request(lreq), .serial_transmit_line(txd),
		.clk_src_internal(clk_int), .clk_src_terminal(tclk), .clk_src_recovered(rclk),
		.peer_rate_valid(pv), .peer_rate_code(pc), .peer_line_kbps(pl),
		.tx_clock_mode(mode), .loopback_enable(loop), .terminal_rate_code(rcode),
		.terminal_rate_kbps(rkbps), .line_rate_kbps(lkbps), .restore_defaults(rstd),
		.sample_on_falling(fall), .plug_and_play_active(pnp), .config_invalid(inv),
		.terminal_tx_clock_out(tco), .tx_data_bit(tbit), .tx_data_strobe(stb));

	msc_peer_model u_msc_peer_model (
		.clk_sys(clk_sys), .clk_src_terminal(tclk), .clk_src_recovered(rclk),
		.serial_transmit_line(txd), .peer_rate_valid(pv), .peer_rate_code(pc),
		.peer_line_kbps(pl));

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Twenty cycles cover sync, a short debounce and the output register.
	task automatic setsw(input logic [7:0] s2, input logic [7:0] s3);
		@(negedge clk_sys);
		b2 = s2;
		b3 = s3;
		repeat (20) @(negedge clk_sys);
	endtask : setsw

	function automatic logic [7:0] b3r(input int c);
		return {2'b11, ~6'(c + (c > 24 ? 3 : 2))};
	endfunction : b3r

	task automatic results;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_clock;
		logic [7:0] sel [3] = '{8'h60, 8'h40, 8'h20};
		for (int i = 2; i >= 0; i--) begin
			setsw(sel[i], 8'hf1);
			chk(12'(mode), 12'(i));
			chk(12'(inv), 12'h0);
		end
		setsw(8'h00, 8'hf1);
		chk(12'(mode), 12'h0);
		chk(12'(inv), 12'h1);
		$display("t_clock done");
	endtask : t_clock

	task automatic t_loop;
		for (int e = 1; e >= 0; e--) begin
			setsw(e ? 8'he0 : 8'h60, 8'hf1);
			lreq = 1'b1;
			repeat (6) @(negedge clk_sys);
			chk(12'(loop), 12'(e));
			lreq = 1'b0;
			repeat (6) @(negedge clk_sys);
			chk(12'(loop), 12'h0);
		end
		$display("t_loop done");
	endtask : t_loop

	task automatic t_rate;
		int cs [7] = '{1, 2, 17, 19, 24, 25, 36};
		int k;
		int n;
		foreach (cs[i]) begin
			k = cs[i] * 64;
			setsw(8'h60, b3r(cs[i]));
			chk(12'(rcode), 12'(cs[i]));
			chk(rkbps, 12'(k));
			chk(lkbps, 12'(k > 128 ? k + 16 : 144));
		end
		b3 = b3r(5);
		@(negedge clk_sys);
		b3 = b3r(36);
		n = 0;
		repeat (20) @(negedge clk_sys) n += (rcode === 6'h05);
		chk(12'(n), 12'h000);
		chk(12'(rcode), 12'h024);
		setsw(8'h60, {2'b11, ~6'h14});
		chk(12'(rcode), 12'h024);
		chk(12'(inv), 12'h1);
		$display("t_rate done");
	endtask : t_rate

	task automatic t_edge;
		int n;
		for (int e = 0; e < 2; e++) begin
			setsw(8'hc0, e ? 8'h31 : 8'hf1);
			chk(12'(rstd), 12'(e));
			chk(12'(fall), 12'(!e));
			n = 0;
			repeat (200) begin
				@(negedge clk_sys);
				if (stb === 1'b1) begin
					n++;
					chk(12'(tbit), 12'(txd));
					chk(12'(tco), 12'(e));
				end
			end
			chk(12'(n > 2), 12'h1);
		end
		$display("t_edge done");
	endtask : t_edge

	task automatic t_pnp;
		strap = 1'b1;
		lreq = 1'b1;
		setsw(8'hff, 8'hff);
		chk(12'(pnp), 12'h1);
		chk(12'(mode), 12'h2);
		chk(12'(rcode), 12'h00c);
		chk(12'(loop), 12'h0);
		u_msc_peer_model.offer(6'h14, 12'h578);
		@(negedge clk_sys);
		chk(12'(rcode), 12'h014);
		chk(rkbps, 12'h500);
		chk(lkbps, 12'h578);
		u_msc_peer_model.offer(6'h00, 12'h7ff);
		@(negedge clk_sys);
		chk(12'(rcode), 12'h014);
		chk(lkbps, 12'h578);
		lreq = 1'b0;
		$display("t_pnp done");
	endtask : t_pnp

	initial begin
		repeat (2) @(negedge clk_sys);
		chk(lkbps, 12'h310);
		rst = 1'b0;
		t_clock();
		t_loop();
		t_rate();
		t_edge();
		t_pnp();
		results();
	end

	initial begin
		#200000;
		errors++;
		results();
	end
endmodule : tb_top
